// *** rtl/lsad_pkg.sv ***
// package of operation codes, widths and bus constants for the execution datapath
package lsad_pkg;
   // ==========================================================
   // widths
   localparam int unsigned LSAD_XLEN      = 32;
   localparam int unsigned LSAD_IMM_W     = 16;
   localparam int unsigned LSAD_LANES     = 4;
   // ==========================================================
   // reset values and byte-enable masks
   localparam logic [31:0] LSAD_RST_WORD  = 32'h0000_0000;
   localparam logic [3:0]  LSAD_RST_BE    = 4'h0;
   localparam logic [3:0]  LSAD_BE_WORD   = 4'hf;
   localparam logic [3:0]  LSAD_BE_HALF   = 4'h3;
   localparam logic [3:0]  LSAD_BE_BYTE   = 4'h1;
   // ==========================================================
   // operation codes
   typedef enum logic [5:0] {
      LSAD_OP_AND    = 6'h00, LSAD_OP_OR     = 6'h01, LSAD_OP_XOR    = 6'h02,
      LSAD_OP_NOR    = 6'h03, LSAD_OP_ANDI   = 6'h04, LSAD_OP_ORI    = 6'h05,
      LSAD_OP_XORI   = 6'h06, LSAD_OP_ANDHI  = 6'h07, LSAD_OP_ORHI   = 6'h08,
      LSAD_OP_XORHI  = 6'h09, LSAD_OP_ADD    = 6'h0a, LSAD_OP_SUB    = 6'h0b,
      LSAD_OP_MUL    = 6'h0c, LSAD_OP_DIV    = 6'h0d, LSAD_OP_DIVU   = 6'h0e,
      LSAD_OP_ADDI   = 6'h0f, LSAD_OP_SUBI   = 6'h10, LSAD_OP_MULI   = 6'h11,
      LSAD_OP_MULXSS = 6'h12, LSAD_OP_MULXUU = 6'h13, LSAD_OP_MULXSU = 6'h14,
      LSAD_OP_MOV    = 6'h15, LSAD_OP_MOVI   = 6'h16, LSAD_OP_MOVUI  = 6'h17,
      LSAD_OP_MOVHI  = 6'h18, LSAD_OP_LDW    = 6'h20, LSAD_OP_STW    = 6'h21,
      LSAD_OP_LDB    = 6'h22, LSAD_OP_LDBU   = 6'h23, LSAD_OP_LDH    = 6'h24,
      LSAD_OP_LDHU   = 6'h25, LSAD_OP_STB    = 6'h26, LSAD_OP_STH    = 6'h27
   } lsad_op_type;
   // ==========================================================
   // states, gray along idle -> bus -> wait -> done
   typedef enum logic [1:0] {
      LSAD_ST_IDLE = 2'b00,
      LSAD_ST_BUS  = 2'b01,
      LSAD_ST_WAIT = 2'b11,
      LSAD_ST_DONE = 2'b10
   } lsad_state_type;
endpackage : lsad_pkg

// *** rtl/lsad_datapath.sv ***
// execution datapath: alu, multiply-high, moves, loads and stores on the data master port
// Overview of operation
// - memory touched only by loads and stores; alu uses register operands only
// - cached word access address is base plus sign-extended immediate, 32-bit data
// - cached accesses may be reordered or suppressed; here they are passed through
// - uncached word accesses bypass cache, stay in order, never suppressed
// - signed byte and half loads sign-extend to 32 bits
// - unsigned byte and half loads zero-extend to 32 bits
// - narrow stores write only the low byte or half of the source
// - uncached variants of all narrow loads and stores exist
// - and, or, xor, nor combine two registers bitwise
// - low-immediate logic forms zero-extend the 16-bit immediate
// - high-immediate logic forms put the immediate in the upper half
// - add, sub, mul, signed and unsigned divide on two registers
// - immediate add, sub, mul use a signed 16-bit immediate
// - signed and unsigned multiply-high return product upper word standalone
// - mixed signed-by-unsigned multiply-high is provided
// - register move copies the value unchanged
// - signed immediate move sign-extends to 32 bits
// - unsigned and high immediate moves fill one half, zero the other
// - little-endian: higher bytes at higher addresses
// - 32-bit data bus carrying byte, half and word transfers
`timescale 1ns/1ps
`default_nettype none
module lsad_datapath #(
   parameter int unsigned XLEN = lsad_pkg::LSAD_XLEN
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  req_valid_i,   // decoder issues one operation
   input  wire lsad_pkg::lsad_op_type req_op_i,
   input  wire logic                  req_uncached_i, // io variant of a memory op
   input  wire logic [XLEN-1:0]       req_a_i,
   input  wire logic [XLEN-1:0]       req_b_i,
   input  wire logic [15:0]           req_imm_i,
   input  wire logic [4:0]            req_dest_i,
   output logic                       req_ready_o,
   output logic                       wb_valid_o,
   output logic [4:0]                 wb_dest_o,
   output logic [XLEN-1:0]            wb_data_o,
   output logic                       bus_read_o,
   output logic                       bus_write_o,
   output logic                       bus_uncached_o,
   output logic [XLEN-1:0]            bus_address_o,
   output logic [3:0]                 bus_byteenable_o,
   output logic [XLEN-1:0]            bus_writedata_o,
   input  wire logic [XLEN-1:0]       bus_readdata_i,
   input  wire logic                  bus_waitrequest_i,
   input  wire logic                  bus_readdatavalid_i
);
   import lsad_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      lsad_state_type    st;
      logic              rdy;
      logic              wbv;
      logic [4:0]        dest;
      logic [XLEN-1:0]   wbd;
      logic              rd;
      logic              wr;
      logic              unc;
      logic [XLEN-1:0]   adr;
      logic [3:0]        be;
      logic [XLEN-1:0]   wdat;
      lsad_op_type       op;
      logic [1:0]        lane;
   } lsad_reg_type;

   lsad_reg_type r_q;
   lsad_reg_type r_d;

   // ==========================================================
   // operand preparation
   logic [XLEN-1:0]   imm_sx;
   logic [XLEN-1:0]   imm_zx;
   logic [XLEN-1:0]   imm_hi;
   logic [2*XLEN-1:0] prod_ss;
   logic [2*XLEN-1:0] prod_uu;
   logic [2*XLEN:0]   prod_su;
   logic [XLEN-1:0]   alu_res;
   logic              is_mem;
   logic              is_load;
   logic [XLEN-1:0]   ld_word;
   logic [XLEN-1:0]   ld_res;

   assign imm_sx = {{(XLEN-16){req_imm_i[15]}}, req_imm_i};
   assign imm_zx = {{(XLEN-16){1'b0}}, req_imm_i};
   assign imm_hi = {req_imm_i, {(XLEN-16){1'b0}}};
   // full products, upper words taken without needing a prior low multiply
   assign prod_ss = $signed(req_a_i) * $signed(req_b_i);
   assign prod_uu = req_a_i * req_b_i;
   assign prod_su = $signed({req_a_i[XLEN-1], req_a_i}) * $signed({1'b0, req_b_i});

   // register-operand alu, no memory path involved
   always_comb begin
      alu_res = LSAD_RST_WORD;
      unique case (req_op_i)
         LSAD_OP_AND:    alu_res = req_a_i & req_b_i;
         LSAD_OP_OR:     alu_res = req_a_i | req_b_i;
         LSAD_OP_XOR:    alu_res = req_a_i ^ req_b_i;
         LSAD_OP_NOR:    alu_res = ~(req_a_i | req_b_i);
         LSAD_OP_ANDI:   alu_res = req_a_i & imm_zx;
         LSAD_OP_ORI:    alu_res = req_a_i | imm_zx;
         LSAD_OP_XORI:   alu_res = req_a_i ^ imm_zx;
         LSAD_OP_ANDHI:  alu_res = req_a_i & imm_hi;
         LSAD_OP_ORHI:   alu_res = req_a_i | imm_hi;
         LSAD_OP_XORHI:  alu_res = req_a_i ^ imm_hi;
         LSAD_OP_ADD:    alu_res = req_a_i + req_b_i;
         LSAD_OP_SUB:    alu_res = req_a_i - req_b_i;
         LSAD_OP_MUL:    alu_res = prod_uu[XLEN-1:0];
         // divide by zero yields all ones, a choice of this block
         LSAD_OP_DIV:    alu_res = (req_b_i == '0) ? '1 :
                                   XLEN'($signed(req_a_i) / $signed(req_b_i));
         LSAD_OP_DIVU:   alu_res = (req_b_i == '0) ? '1 : req_a_i / req_b_i;
         LSAD_OP_ADDI:   alu_res = req_a_i + imm_sx;
         LSAD_OP_SUBI:   alu_res = req_a_i - imm_sx;
         LSAD_OP_MULI:   alu_res = XLEN'(req_a_i * imm_sx);
         LSAD_OP_MULXSS: alu_res = prod_ss[2*XLEN-1:XLEN];
         LSAD_OP_MULXUU: alu_res = prod_uu[2*XLEN-1:XLEN];
         LSAD_OP_MULXSU: alu_res = prod_su[2*XLEN-1:XLEN];
         LSAD_OP_MOV:    alu_res = req_a_i;
         LSAD_OP_MOVI:   alu_res = imm_sx;
         LSAD_OP_MOVUI:  alu_res = imm_zx;
         LSAD_OP_MOVHI:  alu_res = imm_hi;
         default:        alu_res = LSAD_RST_WORD;
      endcase
   end

   assign is_mem  = req_op_i inside {LSAD_OP_LDW, LSAD_OP_STW, LSAD_OP_LDB, LSAD_OP_LDBU,
                                     LSAD_OP_LDH, LSAD_OP_LDHU, LSAD_OP_STB, LSAD_OP_STH};
   assign is_load = req_op_i inside {LSAD_OP_LDW, LSAD_OP_LDB, LSAD_OP_LDBU,
                                     LSAD_OP_LDH, LSAD_OP_LDHU};

   // ==========================================================
   // load alignment, little-endian lane select and extension
   always_comb begin
      ld_word = bus_readdata_i >> {r_q.lane, 3'b000};
      ld_res  = ld_word;
      unique case (r_q.op)
         LSAD_OP_LDB:  ld_res = {{(XLEN-8){ld_word[7]}}, ld_word[7:0]};
         LSAD_OP_LDH:  ld_res = {{(XLEN-16){ld_word[15]}}, ld_word[15:0]};
         LSAD_OP_LDBU: ld_res = {{(XLEN-8){1'b0}}, ld_word[7:0]};
         LSAD_OP_LDHU: ld_res = {{(XLEN-16){1'b0}}, ld_word[15:0]};
         default:      ld_res = bus_readdata_i;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      logic [XLEN-1:0] ea;
      logic [3:0]      be;
      ea   = req_a_i + imm_sx;
      be   = LSAD_BE_WORD;
      r_d  = r_q;
      r_d.wbv = 1'b0;
      unique case (r_q.st)
         LSAD_ST_IDLE: begin
            if (req_valid_i && r_q.rdy) begin
               r_d.dest = req_dest_i;
               if (!is_mem) begin
                  r_d.wbv = 1'b1;
                  r_d.wbd = alu_res;
               end else begin
                  // narrow accesses enable only their own lanes
                  unique case (req_op_i)
                     LSAD_OP_LDB, LSAD_OP_LDBU, LSAD_OP_STB: be = LSAD_BE_BYTE << ea[1:0];
                     LSAD_OP_LDH, LSAD_OP_LDHU, LSAD_OP_STH: be = LSAD_BE_HALF << {ea[1], 1'b0};
                     default: be = LSAD_BE_WORD;
                  endcase
                  r_d.st   = LSAD_ST_BUS;
                  r_d.rdy  = 1'b0;
                  r_d.op   = req_op_i;
                  r_d.lane = ea[1:0];
                  r_d.adr  = {ea[XLEN-1:2], 2'b00};
                  r_d.be   = be;
                  r_d.unc  = req_uncached_i;
                  r_d.rd   = is_load;
                  r_d.wr   = !is_load;
                  // low byte or half replicated across all four lanes; byte enables select the addressed one
                  unique case (req_op_i)
                     LSAD_OP_STB: r_d.wdat = {4{req_b_i[7:0]}};
                     LSAD_OP_STH: r_d.wdat = {2{req_b_i[15:0]}};
                     default:     r_d.wdat = req_b_i;
                  endcase
               end
            end
         end
         // every access is issued, cached or not, one at a time in order
         LSAD_ST_BUS: begin
            if (!bus_waitrequest_i) begin
               r_d.rd = 1'b0;
               r_d.wr = 1'b0;
               r_d.st = r_q.rd ? LSAD_ST_WAIT : LSAD_ST_DONE;
            end
         end
         LSAD_ST_WAIT: begin
            if (bus_readdatavalid_i) begin
               r_d.wbv = 1'b1;
               r_d.wbd = ld_res;
               r_d.st  = LSAD_ST_DONE;
            end
         end
         LSAD_ST_DONE: begin
            r_d.st  = LSAD_ST_IDLE;
            r_d.rdy = 1'b1;
            r_d.be  = LSAD_RST_BE;
            r_d.unc = 1'b0;
         end
         default: r_d.st = LSAD_ST_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         r_q <= '{st: LSAD_ST_IDLE, rdy: 1'b1, wbv: 1'b0, dest: 5'h00, wbd: LSAD_RST_WORD,
                  rd: 1'b0, wr: 1'b0, unc: 1'b0, adr: LSAD_RST_WORD, be: LSAD_RST_BE,
                  wdat: LSAD_RST_WORD, op: LSAD_OP_AND, lane: 2'h0};
      end else begin
         r_q <= r_d;
      end
   end

   assign req_ready_o      = r_q.rdy;
   assign wb_valid_o       = r_q.wbv;
   assign wb_dest_o        = r_q.dest;
   assign wb_data_o        = r_q.wbd;
   assign bus_read_o       = r_q.rd;
   assign bus_write_o      = r_q.wr;
   assign bus_uncached_o   = r_q.unc;
   assign bus_address_o    = r_q.adr;
   assign bus_byteenable_o = r_q.be;
   assign bus_writedata_o  = r_q.wdat;

   // ==========================================================
   // checks
   // effective address recomputed for the address check
   logic [XLEN-1:0] ea_chk;
   assign ea_chk = req_a_i + imm_sx;

   a_alu_one_cycle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && !is_mem |=> wb_valid_o && !bus_read_o && !bus_write_o)
      else $error("alu op did not write back alone");
   a_movhi_half: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && req_op_i == LSAD_OP_MOVHI |=> wb_data_o[15:0] == 16'h0000)
      else $error("high move left lower half set");
   a_movi_sign: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && req_op_i == LSAD_OP_MOVI |=> wb_data_o == $past(imm_sx))
      else $error("signed immediate move wrong");
   a_andi_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && req_op_i == LSAD_OP_ANDI |=> wb_data_o[31:16] == 16'h0000)
      else $error("low immediate and not zero-extended");
   a_mem_issue: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && is_mem |=> (bus_read_o || bus_write_o) && !req_ready_o)
      else $error("memory op not issued on the bus");
   a_addr_align: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && is_mem |=> bus_address_o == {$past(ea_chk[XLEN-1:2]), 2'b00})
      else $error("effective address wrong");
   a_byte_lanes: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      bus_write_o && r_q.op == LSAD_OP_STB |-> $onehot(bus_byteenable_o))
      else $error("byte store enabled several lanes");
   a_ldbu_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      wb_valid_o && r_q.op == LSAD_OP_LDBU && r_q.st == LSAD_ST_DONE |-> wb_data_o[31:8] == 24'h0)
      else $error("unsigned byte load not zero-extended");
   a_ldb_sign: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      wb_valid_o && r_q.op == LSAD_OP_LDB && r_q.st == LSAD_ST_DONE |-> wb_data_o[31:8] == {24{wb_data_o[7]}})
      else $error("signed byte load not sign-extended");
   a_unc_mirror: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && is_mem |=> bus_uncached_o == $past(req_uncached_i))
      else $error("uncached flag not carried to the bus");
   a_half_lanes: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      bus_write_o && r_q.op == LSAD_OP_STH |-> bus_byteenable_o inside {4'h3, 4'hc})
      else $error("half store enabled wrong lanes");
   a_ldhu_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      wb_valid_o && r_q.op == LSAD_OP_LDHU && r_q.st == LSAD_ST_DONE |-> wb_data_o[31:16] == 16'h0000)
      else $error("unsigned half load not zero-extended");
   a_mov_copy: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      req_valid_i && req_ready_o && req_op_i == LSAD_OP_MOV |=> wb_data_o == $past(req_a_i))
      else $error("register move changed the value");
endmodule : lsad_datapath
`default_nettype wire

// *** test/lsad_mem_model.sv ***
// memory and peripheral slave model for the datapath data master port
`timescale 1ns/1ps
`default_nettype none
module lsad_mem_model (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        slow_i,            // two wait states per access
   input  wire logic        bus_read_i,
   input  wire logic        bus_write_i,
   input  wire logic [31:0] bus_address_i,
   input  wire logic [3:0]  bus_byteenable_i,
   input  wire logic [31:0] bus_writedata_i,
   output logic [31:0]      bus_readdata_o,
   output logic             bus_waitrequest_o,
   output logic             bus_readdatavalid_o
);
   logic [31:0] mem_q [0:15];
   logic [1:0]  ws_q;
   // ==========================================================
   // hold off each access while slow mode is on
   assign bus_waitrequest_o = (bus_read_i | bus_write_i) & slow_i & (ws_q != 2'h2);
   // ==========================================================
   // accept accesses; idle read data toggles so stale values never match
   always_ff @(posedge ref_clk_i) begin
      bus_readdatavalid_o <= 1'b0;
      bus_readdata_o      <= ~bus_readdata_o;
      ws_q                <= (bus_waitrequest_o && !sys_rst_i) ? ws_q + 2'h1 : 2'h0;
      if (sys_rst_i) begin
         bus_readdata_o <= 32'h0000_0000;
      end else if ((bus_read_i | bus_write_i) && !bus_waitrequest_o) begin
         if (bus_read_i) begin
            bus_readdatavalid_o <= 1'b1;
            bus_readdata_o      <= mem_q[bus_address_i[5:2]];
         end
         for (int i = 0; i < 4; i++) begin
            if (bus_write_i && bus_byteenable_i[i]) begin
               mem_q[bus_address_i[5:2]][8*i +: 8] <= bus_writedata_i[8*i +: 8]; // lane i at offset i
            end
         end
      end
   end
endmodule : lsad_mem_model
`default_nettype wire

// *** test/lsad_datapath_tb_top.sv ***
// self-checking bench for the execution datapath against a memory slave model
`timescale 1ns/1ps
`default_nettype none
module lsad_datapath_tb_top;
   import lsad_pkg::*;
   logic        ref_clk_i, sys_rst_i, req_valid_i, req_uncached_i, slow_i, cap_unc;
   lsad_op_type req_op_i;
   logic [31:0] req_a_i, req_b_i, wb_data_o, bus_address_o, bus_writedata_o, bus_readdata_i;
   logic [31:0] cap_adr, cap_wd;
   logic [15:0] req_imm_i;
   logic [4:0]  req_dest_i, wb_dest_o;
   logic [3:0]  bus_byteenable_o, cap_be;
   logic        req_ready_o, wb_valid_o, bus_read_o, bus_write_o, bus_uncached_o;
   logic        bus_waitrequest_i, bus_readdatavalid_i;
   int          n_errors, checks, cycles;
   // ==========================================================
   // design and slave model
   lsad_datapath DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
      .req_op_i(req_op_i), .req_uncached_i(req_uncached_i), .req_a_i(req_a_i), .req_b_i(req_b_i),
      .req_imm_i(req_imm_i), .req_dest_i(req_dest_i), .req_ready_o(req_ready_o), .wb_valid_o(wb_valid_o),
      .wb_dest_o(wb_dest_o), .wb_data_o(wb_data_o), .bus_read_o(bus_read_o), .bus_write_o(bus_write_o),
      .bus_uncached_o(bus_uncached_o), .bus_address_o(bus_address_o), .bus_byteenable_o(bus_byteenable_o),
      .bus_writedata_o(bus_writedata_o), .bus_readdata_i(bus_readdata_i),
      .bus_waitrequest_i(bus_waitrequest_i), .bus_readdatavalid_i(bus_readdatavalid_i));
   lsad_mem_model mem_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow_i),
      .bus_read_i(bus_read_o), .bus_write_i(bus_write_o), .bus_address_i(bus_address_o),
      .bus_byteenable_i(bus_byteenable_o), .bus_writedata_i(bus_writedata_o), .bus_readdata_o(bus_readdata_i),
      .bus_waitrequest_o(bus_waitrequest_i), .bus_readdatavalid_o(bus_readdatavalid_i));
   // ==========================================================
   // 40 MHz clock and hang watchdog
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("MISMATCH watchdog expected completion seen hang");
         stop_test();
      end
   end
   // ==========================================================
   // compare, report, issue one operation and follow it to completion
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   task automatic run(input lsad_op_type op, input logic unc, input logic [31:0] a, input logic [31:0] b,
                      input logic [15:0] imm, output logic [31:0] res, output int nbus);
      int   n;
      logic got, wr;
      n = 0;
      got = 1'b0;
      wr = 1'b0;
      nbus = 0;
      res = 32'hxxxx_xxxx;
      @(posedge ref_clk_i);
      req_valid_i    <= 1'b1;
      req_op_i       <= op;
      req_uncached_i <= unc;
      req_a_i        <= a;
      req_b_i        <= b;
      req_imm_i      <= imm;
      req_dest_i     <= req_dest_i + 5'h1;
      @(posedge ref_clk_i);
      req_valid_i <= 1'b0;
      while (n < 40) begin
         #1;
         if ((bus_read_o | bus_write_o) & ~bus_waitrequest_i) begin
            nbus++;
            wr = bus_write_o;
            {cap_be, cap_adr, cap_wd, cap_unc} = {bus_byteenable_o, bus_address_o, bus_writedata_o, bus_uncached_o};
         end
         if (wb_valid_o === 1'b1) begin
            got = 1'b1;
            res = wb_data_o;
            chk("wb_dest", {27'h0, req_dest_i}, {27'h0, wb_dest_o});
         end
         if (req_ready_o === 1'b1 && n > 0 && (got || wr)) break;
         @(posedge ref_clk_i);
         n++;
      end
      if (n == 40) chk("completion", 32'h1, 32'h0);
   endtask : run
   task automatic alu(input lsad_op_type op, input logic [31:0] a, input logic [31:0] b, input logic [15:0] imm,
                      input logic [31:0] exp);
      logic [31:0] r;
      int          nb;
      run(op, 1'b0, a, b, imm, r, nb);
      chk(op.name(), exp, r);
      chk("alu bus cycles", 32'h0, 32'(nb));
   endtask : alu
   task automatic mem(input lsad_op_type op, input logic unc, input logic [31:0] a, input logic [15:0] imm,
                      input logic [31:0] d, output logic [31:0] r);
      int nb;
      run(op, unc, a, d, imm, r, nb);
      chk("bus cycles", 32'h1, 32'(nb));
      chk("uncached flag", {31'h0, unc}, {31'h0, cap_unc});
   endtask : mem
   // ==========================================================
   // scenarios
   task automatic t_mulhi();
      logic [31:0] a, b;
      logic [63:0] p;
      a = 32'h8000_0003;
      b = 32'hffff_fff0;
      p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      alu(LSAD_OP_MULXSS, a, b, 16'h0000, p[63:32]);
      p = {32'h0, a} * {32'h0, b};
      alu(LSAD_OP_MULXUU, a, b, 16'h0000, p[63:32]);
      p = {{32{a[31]}}, a} * {32'h0, b};
      alu(LSAD_OP_MULXSU, a, b, 16'h0000, p[63:32]);
   endtask : t_mulhi
   task automatic t_logic();
      logic [31:0] a, b;
      logic [15:0] i;
      a = 32'hf0f0_a5a5;
      b = 32'hff00_0ff0;
      i = 16'h8001;
      alu(LSAD_OP_AND, a, b, i, a & b);
      alu(LSAD_OP_OR, a, b, i, a | b);
      alu(LSAD_OP_XOR, a, b, i, a ^ b);
      alu(LSAD_OP_NOR, a, b, i, ~(a | b));
      alu(LSAD_OP_ANDI, a, b, i, a & {16'h0, i});
      alu(LSAD_OP_ORI, a, b, i, a | {16'h0, i});
      alu(LSAD_OP_XORI, a, b, i, a ^ {16'h0, i});
      alu(LSAD_OP_ANDHI, a, b, i, a & {i, 16'h0});
      alu(LSAD_OP_ORHI, a, b, i, a | {i, 16'h0});
      alu(LSAD_OP_XORHI, a, b, i, a ^ {i, 16'h0});
      alu(LSAD_OP_MOV, a, b, i, a);
      alu(LSAD_OP_MOVI, a, b, i, 32'hffff_8001);
      alu(LSAD_OP_MOVUI, a, b, i, 32'h0000_8001);
      alu(LSAD_OP_MOVHI, a, b, i, 32'h8001_0000);
   endtask : t_logic
   task automatic t_arith();
      logic [31:0] a, b;
      a = 32'hffff_fff9;
      b = 32'h0000_0003;
      alu(LSAD_OP_ADD, a, b, 16'h0000, a + b);
      alu(LSAD_OP_SUB, a, b, 16'h0000, a - b);
      alu(LSAD_OP_MUL, a, b, 16'h0000, a * b);
      alu(LSAD_OP_DIV, a, b, 16'h0000, 32'($signed(a) / $signed(b)));
      alu(LSAD_OP_DIVU, a, b, 16'h0000, a / b);
      alu(LSAD_OP_DIVU, a, 32'h0, 16'h0000, 32'hffff_ffff);
      alu(LSAD_OP_ADDI, a, b, 16'hfffe, a + 32'hffff_fffe);
      alu(LSAD_OP_SUBI, a, b, 16'hfffe, a - 32'hffff_fffe);
      alu(LSAD_OP_MULI, a, b, 16'hfffe, a * 32'hffff_fffe);
   endtask : t_arith
   task automatic t_store_narrow();
      logic [31:0] r;
      mem(LSAD_OP_STW, 1'b0, 32'h0000_0020, 16'hfff0, 32'h1122_3344, r);
      chk("stw address", 32'h0000_0010, cap_adr);
      chk("stw lanes", 32'hf, {28'h0, cap_be});
      mem(LSAD_OP_STB, 1'b1, 32'h0000_0011, 16'h0000, 32'haabb_ccdd, r);
      chk("stb lanes", 32'h2, {28'h0, cap_be});
      chk("stb lane data", 32'hdd, {24'h0, cap_wd[15:8]});
      mem(LSAD_OP_STH, 1'b0, 32'h0000_0012, 16'h0000, 32'h5566_7788, r);
      chk("sth lanes", 32'hc, {28'h0, cap_be});
      chk("sth lane data", 32'h7788, {16'h0, cap_wd[31:16]});
      mem(LSAD_OP_LDW, 1'b0, 32'h0000_0010, 16'h0000, 32'h0, r);
      chk("merged word", 32'h7788_dd44, r);
   endtask : t_store_narrow
   task automatic t_load_ext();
      logic [31:0] r, w;
      w = 32'h80ff_7f01;
      mem(LSAD_OP_STW, 1'b1, 32'h0000_0020, 16'h0000, w, r);
      for (int k = 0; k < 4; k++) begin
         mem(LSAD_OP_LDB, k[0], 32'h0000_0020, 16'(k), 32'h0, r);
         chk("ldb", {{24{w[8*k+7]}}, w[8*k +: 8]}, r);
         mem(LSAD_OP_LDBU, k[1], 32'h0000_0020, 16'(k), 32'h0, r);
         chk("ldbu", {24'h0, w[8*k +: 8]}, r);
      end
      for (int k = 0; k < 4; k += 2) begin
         mem(LSAD_OP_LDH, k[1], 32'h0000_0020, 16'(k), 32'h0, r);
         chk("ldh", {{16{w[8*k+15]}}, w[8*k +: 16]}, r);
         mem(LSAD_OP_LDHU, ~k[1], 32'h0000_0020, 16'(k), 32'h0, r);
         chk("ldhu", {16'h0, w[8*k +: 16]}, r);
      end
   endtask : t_load_ext
   task automatic t_io_order();
      logic [31:0] r;
      slow_i <= 1'b1;
      mem(LSAD_OP_STW, 1'b1, 32'h0000_0030, 16'h0000, 32'h5a5a_0001, r);
      mem(LSAD_OP_STW, 1'b1, 32'h0000_0030, 16'h0000, 32'h5a5a_0002, r);
      mem(LSAD_OP_LDW, 1'b1, 32'h0000_0030, 16'h0000, 32'h0, r);
      chk("io load after io stores", 32'h5a5a_0002, r);
      mem(LSAD_OP_LDW, 1'b0, 32'h0000_0030, 16'h0000, 32'h0, r);
      chk("cached load", 32'h5a5a_0002, r);
      slow_i <= 1'b0;
   endtask : t_io_order
   // ==========================================================
   // main sequence
   initial begin
      {n_errors, checks, cycles} = '0;
      {sys_rst_i, req_valid_i, req_uncached_i, slow_i} = 4'h8;
      {req_a_i, req_b_i, req_imm_i, req_dest_i} = '0;
      req_op_i = LSAD_OP_AND;
      repeat (16) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_mulhi();
      t_logic();
      t_arith();
      t_store_narrow();
      t_load_ext();
      t_io_order();
      stop_test();
   end
endmodule : lsad_datapath_tb_top
`default_nettype wire
